// ---- ior_pkg.sv ----
// How it works
// - each edge cell has a capture register cap_q plus one extra latch lat2_q that together give double-rate output; sdr_q serves single-rate only.
// - in single-rate mode the first core data input goes into one storage element that drives the pad.
// - the single-rate storage element is either an edge flip-flop or a transparent latch, by configuration.
// - in double-rate mode both core data inputs are captured into separate registers on the rising edge.
// - in double-rate mode the registered second input passes an extra latch in the next cycle.
// - a mux selected by the phase bit ph_q[0], which toggles every clock while the cell runs and is held at 0 otherwise, picks which stored value drives the pad.
// - a gearbox mode joins a complementary cell pair and accepts four parallel core streams.
// - before and during programming the output driver is high impedance with an input pull-up.
// - after programming an unused cell keeps its weak input pull-up.
package ior_pkg;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IOR_MODE_SDR  = 2'h0,
    IOR_MODE_DDR  = 2'h1,
    IOR_MODE_GEAR = 2'h2,
    IOR_MODE_OFF  = 2'h3
  } ior_mode_e;

  typedef enum logic [1:0] {
    IOR_ST_UNCFG = 2'h0,
    IOR_ST_PROG  = 2'h1,
    IOR_ST_RUN   = 2'h2
  } ior_state_e;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int        IOR_FIFO_DEPTH = 32;
  localparam int        IOR_GEAR_LANES = 4;
  localparam logic      IOR_RST_PAD    = 1'h0;
  localparam logic [1:0] IOR_RST_PHASE = 2'h0;

endpackage : ior_pkg

// ---- ior_fifo_if.sv ----
`timescale 1ns/1ns
interface ior_fifo_if #(
  parameter int WIDTH = 4
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (
    input  in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
  modport user (
    output in_valid, in_data, out_ready,
    input  in_ready, out_valid, out_data
  );
endinterface : ior_fifo_if

// ---- ior_fifo.sv ----
`timescale 1ns/1ns
module ior_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  ior_fifo_if.fifo  port
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  always_comb begin
    push = port.in_valid && port.in_ready;
    pop  = port.out_valid && port.out_ready;
    wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= port.in_data;
    end
  end

  assign port.in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign port.out_valid = (cnt_q != '0);
  assign port.out_data  = mem_q[rd_q];
endmodule // ior_fifo

// ---- ior_out_reg.sv ----
`timescale 1ns/1ns
module ior_out_reg
  import ior_pkg::*;
#(
  parameter int DEPTH = IOR_FIFO_DEPTH
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       latch_mode_i,
  input  wire logic       prog_done_i,
  input  wire logic       cell_used_i,
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  input  wire logic       out_data_first_i,
  input  wire logic       out_data_second_i,
  input  wire logic       gearbox_stream_a0_i,
  input  wire logic       gearbox_stream_a1_i,
  input  wire logic       gearbox_stream_b0_i,
  input  wire logic       gearbox_stream_b1_i,
  output logic            pad_output_o,
  output logic            pad_output_oe_o,
  output logic            pad_comp_o,
  output logic            pullup_en_o
);

  // ----------------------------------------------------------------
  // reset release and pin sync
  // ----------------------------------------------------------------
  logic       rst_s1_q, rst_b;
  logic       done_s1_q, done_q;
  logic       used_s1_q, used_q;
  logic [1:0] mode_s1_q, mode_q;
  logic       lat_s1_q, lat_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'h0;
      rst_b    <= 1'h0;
    end else begin
      rst_s1_q <= 1'h1;
      rst_b    <= rst_s1_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      done_s1_q <= 1'h0;
      done_q    <= 1'h0;
      used_s1_q <= 1'h0;
      used_q    <= 1'h0;
      mode_s1_q <= IOR_MODE_OFF;
      mode_q    <= IOR_MODE_OFF;
      lat_s1_q  <= 1'h0;
      lat_q     <= 1'h0;
    end else begin
      done_s1_q <= prog_done_i;
      done_q    <= done_s1_q;
      used_s1_q <= cell_used_i;
      used_q    <= used_s1_q;
      mode_s1_q <= mode_i;
      mode_q    <= mode_s1_q;
      lat_s1_q  <= latch_mode_i;
      lat_q     <= lat_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  ior_state_e st_q, st_d;
  ior_mode_e  md;

  always_comb begin
    md   = ior_mode_e'(mode_q);
    st_d = st_q;
    case (st_q)
      IOR_ST_UNCFG: st_d = IOR_ST_PROG;
      IOR_ST_PROG:  st_d = done_q ? IOR_ST_RUN : IOR_ST_PROG;
      IOR_ST_RUN:   st_d = done_q ? IOR_ST_RUN : IOR_ST_PROG;
      default:      st_d = IOR_ST_UNCFG;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= IOR_ST_UNCFG;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // data fifo
  // ----------------------------------------------------------------
  ior_fifo_if #(.WIDTH(IOR_GEAR_LANES)) fif ();

  ior_fifo #(
    .WIDTH (IOR_GEAR_LANES),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i   (clk_i),
    .rst_b_i (rst_b),
    .port    (fif.fifo)
  );

  logic [1:0] ph_q, ph_d;
  logic       run;

  always_comb begin
    run          = (st_q == IOR_ST_RUN) && used_q && (md != IOR_MODE_OFF);
    fif.in_valid = in_valid_i;
    if (md == IOR_MODE_GEAR) begin
      fif.in_data = {gearbox_stream_b1_i, gearbox_stream_b0_i,
                     gearbox_stream_a1_i, gearbox_stream_a0_i};
    end else begin
      fif.in_data = {2'h0, out_data_second_i, out_data_first_i};
    end
    // double rate and gearbox drain one word every two clocks, single rate every clock
    fif.out_ready = run && ((md == IOR_MODE_SDR) || ph_q[0]);
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic [3:0] cap_q, cap_d;
  logic       sdr_q, sdr_d;
  logic       lat2_q, lat2_d;
  logic       pad_d, oe_d, comp_d, pu_d;
  logic       rdy_d;
  logic       pad_q, oe_q, comp_q, pu_q, rdy_q;

  always_comb begin
    cap_d  = cap_q;
    sdr_d  = sdr_q;
    lat2_d = lat2_q;
    ph_d   = run ? 2'(ph_q + 2'h1) : IOR_RST_PHASE;
    rdy_d  = fif.in_ready;
    if (fif.out_valid && fif.out_ready) begin
      cap_d = fif.out_data;
    end
    lat2_d = cap_q[1];
    if (fif.out_valid && fif.out_ready) begin
      sdr_d = fif.out_data[0];
    end
    case (md)
      // latch passes the head straight through
      IOR_MODE_SDR:  pad_d = (lat_q && fif.out_valid) ? fif.out_data[0] : sdr_q;
      IOR_MODE_DDR:  pad_d = ph_q[0] ? lat2_q : cap_q[0];
      IOR_MODE_GEAR: pad_d = ph_q[0] ? cap_q[1] : cap_q[0];
      default:       pad_d = IOR_RST_PAD;
    endcase
    comp_d = ph_q[0] ? cap_q[3] : cap_q[2];
    oe_d = run;
    pu_d = !run;
    if (!run) begin
      pad_d  = IOR_RST_PAD;
      comp_d = IOR_RST_PAD;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cap_q  <= '0;
      sdr_q  <= 1'h0;
      lat2_q <= 1'h0;
      ph_q   <= IOR_RST_PHASE;
      pad_q  <= IOR_RST_PAD;
      oe_q   <= 1'h0;
      comp_q <= IOR_RST_PAD;
      pu_q   <= 1'h1;
      rdy_q  <= 1'h0;
    end else begin
      cap_q  <= cap_d;
      sdr_q  <= sdr_d;
      lat2_q <= lat2_d;
      ph_q   <= ph_d;
      pad_q  <= pad_d;
      oe_q   <= oe_d;
      comp_q <= comp_d;
      pu_q   <= pu_d;
      rdy_q  <= rdy_d;
    end
  end

  assign pad_output_o    = pad_q;
  assign pad_output_oe_o = oe_q;
  assign pad_comp_o      = comp_q;
  assign pullup_en_o     = pu_q;
  assign in_ready_o      = rdy_q;

endmodule // ior_out_reg

// ---- ior_pad_sink.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// off-chip receiver of the pad pair
// ----------------------------------------------------------------
module ior_pad_sink (
  input  wire logic pad_i,
  input  wire logic comp_i,
  input  wire logic oe_i,
  input  wire logic pull_i,
  output logic      line_o,
  output logic      line_c_o
);
  assign line_o   = oe_i ? pad_i : (pull_i | ~pad_i);
  assign line_c_o = oe_i ? comp_i : (pull_i | ~comp_i);
endmodule // ior_pad_sink

// ---- ior_out_reg_properties.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module ior_out_reg_properties (
  input wire logic       clk_i, rst_b_i, prog_done_i, cell_used_i, in_valid_i,
  input wire logic [1:0] mode_i,
  input wire logic       out_data_first_i, out_data_second_i, gearbox_stream_a0_i,
  input wire logic       gearbox_stream_a1_i, gearbox_stream_b0_i, gearbox_stream_b1_i,
  input wire logic       pad_output_o, pad_output_oe_o, pad_comp_o, pullup_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic oe   = pad_output_oe_o;
  wire logic sdr1 = mode_i == 2'h0 && in_valid_i && out_data_first_i && oe;
  wire logic ddr  = mode_i == 2'h1 && in_valid_i && out_data_first_i && !out_data_second_i && oe;
  wire logic gear = mode_i == 2'h2 && in_valid_i && gearbox_stream_a0_i && !gearbox_stream_a1_i
                    && !gearbox_stream_b0_i && gearbox_stream_b1_i && oe;
  property p_unprog_hiz; !prog_done_i [*8] |-> !oe && pullup_en_o; endproperty
  a_unprog_hiz: assert property (p_unprog_hiz) else $error("driver on while unprogrammed");
  property p_unused_pull; !cell_used_i [*8] |-> !oe && pullup_en_o; endproperty
  a_unused_pull: assert property (p_unused_pull) else $error("unused cell lost pull-up");
  property p_hiz_low; !oe |-> !pad_output_o && !pad_comp_o; endproperty
  a_hiz_low: assert property (p_hiz_low) else $error("pad data while released");
  property p_oe_cause; $rose(oe) |-> $past(prog_done_i, 4) && $past(cell_used_i, 3); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("driver on without cause");
  property p_oe_on; (prog_done_i && cell_used_i && mode_i != 2'h3) [*8] |-> ##[0:8] oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("driver never enabled");
  property p_sdr; sdr1 [*8] |-> pad_output_o; endproperty
  a_sdr: assert property (p_sdr) else $error("single rate pad wrong");
  property p_ddr; ddr [*8] |-> pad_output_o != $past(pad_output_o); endproperty
  a_ddr: assert property (p_ddr) else $error("double rate pad not alternating");
  property p_gear; gear [*8] |-> pad_output_o != pad_comp_o; endproperty
  a_gear: assert property (p_gear) else $error("gearbox lanes wrong");
endmodule // ior_out_reg_properties

bind ior_out_reg ior_out_reg_properties chk_u (.*);

// ---- ior_out_reg_bench.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module ior_out_reg_bench;
  import ior_pkg::*;
  logic clk_i = 0, rst_b_i = 0, latch_mode_i = 0, prog_done_i = 0, cell_used_i = 0;
  logic in_valid_i = 0, out_data_first_i = 0, out_data_second_i = 0;
  logic gearbox_stream_a0_i = 0, gearbox_stream_a1_i = 0;
  logic gearbox_stream_b0_i = 0, gearbox_stream_b1_i = 0;
  logic [1:0] mode_i = 2'h0;
  logic in_ready_o, pad_output_o, pad_output_oe_o, pad_comp_o, pullup_en_o, line, line_c, p;
  int error_cnt = 0, compares = 0, n;
  always #50 clk_i = ~clk_i;
  ior_out_reg dut_u (.*);
  ior_pad_sink sink_u (.pad_i(pad_output_o), .comp_i(pad_comp_o), .oe_i(pad_output_oe_o),
    .pull_i(pullup_en_o), .line_o(line), .line_c_o(line_c));
  task automatic check(string nm, logic seen, logic exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic set_run(logic pd, logic cu, logic [1:0] m);
    prog_done_i = pd; cell_used_i = cu; mode_i = m; in_valid_i = 0;
    cyc(16);
  endtask
  task automatic t_unprog;
    set_run(0, 1, 2'h0);
    check("oe", pad_output_oe_o, 0);
    check("line", line, 1);
    set_run(1, 1, 2'h0);
    check("oe", pad_output_oe_o, 1);
    $display("done unprog");
  endtask
  task automatic t_fill;
    set_run(0, 1, 2'h0);
    in_valid_i = 1; n = 0;
    while (in_ready_o === 1'h1 && n < 40) begin cyc(1); n++; end
    check("fill", n == IOR_FIFO_DEPTH + 1, 1);
    set_run(1, 1, 2'h0);
    cyc(40);
    check("drained", in_ready_o, 1);
    $display("done fill");
  endtask
  task automatic t_sdr;
    for (int l = 0; l < 2; l++) for (int v = 1; v >= 0; v--) begin
      latch_mode_i = l;
      cyc(3);
      out_data_first_i = v;
      in_valid_i = 1;
      cyc(2);
      check("sdr early", line, l ? v[0] : ~v[0]);
      cyc(8);
      check("sdr pad", line, v[0]);
      in_valid_i = 0; cyc(8);
    end
    $display("done sdr");
  endtask
  task automatic t_ddr;
    set_run(1, 1, 2'h1);
    for (int v = 0; v < 2; v++) begin
      out_data_first_i = v; out_data_second_i = ~v[0]; in_valid_i = 1;
      cyc(10); p = line; cyc(1);
      check("ddr alt", line, ~p);
      in_valid_i = 0; cyc(16);
    end
    $display("done ddr");
  endtask
  task automatic t_ddr_pair;
    logic [19:0] bits;
    int          hits;
    bits = '0;
    hits = 0;
    out_data_first_i = 0;
    out_data_second_i = 0;
    in_valid_i = 1;
    cyc(1);
    in_valid_i = 0;
    cyc(12);
    for (int i = 0; i < 20; i++) begin
      in_valid_i = (i < 3);
      out_data_first_i = (i == 0);
      out_data_second_i = (i == 1);
      cyc(1);
      bits = {bits[18:0], line};
    end
    for (int i = 0; i < 17; i++) begin
      hits += (bits[i +: 4] == 4'h9);
    end
    check("ddr pair", hits == 1 && $countones(bits) == 2, 1);
    $display("done ddr pair");
  endtask
  task automatic t_gear;
    set_run(1, 1, 2'h2);
    gearbox_stream_a0_i = 1; gearbox_stream_b1_i = 1; in_valid_i = 1;
    cyc(10); p = line; cyc(1);
    check("gear alt", line, ~p);
    check("gear comp", line_c, ~line);
    $display("done gear");
  endtask
  task automatic t_unused;
    set_run(1, 0, 2'h0);
    check("oe", pad_output_oe_o, 0);
    check("pull", pullup_en_o, 1);
    set_run(1, 1, 2'h3);
    check("off oe", pad_output_oe_o, 0);
    check("off pull", pullup_en_o, 1);
    $display("done unused");
  endtask
  task automatic t_reset;
    set_run(1, 1, 2'h0);
    rst_b_i = 0;
    cyc(1);
    check("rst oe", pad_output_oe_o, 0);
    check("rst pull", pullup_en_o, 1);
    check("rst rdy", in_ready_o, 0);
    rst_b_i = 1;
    cyc(2);
    check("rel oe", pad_output_oe_o, 0);
    cyc(14);
    check("rel run", pad_output_oe_o, 1);
    check("rel line", line, 0);
    $display("done reset");
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(2000 * 100);
    error_cnt++;
    print_verdict();
  end
  initial begin
    cyc(2);
    rst_b_i = 1;
    t_unprog(); t_fill(); t_sdr(); t_ddr(); t_ddr_pair(); t_gear(); t_unused(); t_reset();
    print_verdict();
  end
endmodule // ior_out_reg_bench
